// ### verilog/ccrg_pkg.sv
/*
 * Constants, types and state encodings for the cache-resident engine shell:
 * interrupt vectoring, reset sequencing, halt control and the 32-bit ports.
 * Assumes one processor clock and a core that presents fetch, control-bus
 * and data-side port requests as single-cycle strobes.
 */
// Behaviour
// - External interrupt line is level sensitive; high means request.
// - Sources are programmable timer, fixed timer and external line.
// - Taken interrupt fetches from table base plus a per-type offset.
// - Table starts at F0000000; every entry jumps to trap FFFF3FF8.
// - External line ignored while servicing; still high after exit retakes.
// - Output port written via control bus address 3F1, once per 10 cycles.
// - Input port sample every 4 cycles to cache, 2 to a register.
// - Reset logic accepts external requests and watchdog resets.
// - Core system reset request feeds the reset logic for a full reset.
// - System reset notification output tells outside logic of the reset.
// - Reset starts at FFFFFFFC; hardwired code enables icache, jumps FFFF3FFC.
// - Halt controller holds the processor for JTAG-driven startup.
// - Input port read at 01000000 over the data-side memory read bus.
// - Caches are disabled during the reset sequence.
package ccrg_pkg;

    localparam logic [31:0] VEC_TABLE_BASE = 32'hF000_0000;
    localparam logic [15:0] VEC_TABLE_TAG = 16'hF000;
    localparam logic [31:0] TRAP_ADDR = 32'hFFFF_3FF8;
    localparam logic [31:0] RESET_VECTOR = 32'hFFFF_FFFC;
    localparam logic [31:0] USER_ENTRY = 32'hFFFF_3FFC;
    localparam logic [31:0] IN_PORT_ADDR = 32'h0100_0000;
    localparam logic [9:0] OUT_PORT_DCR = 10'h3F1;

    // Per-type offsets into the vector table
    localparam logic [31:0] VEC_OFS_EXT = 32'h0000_0100;
    localparam logic [31:0] VEC_OFS_PIT = 32'h0000_0200;
    localparam logic [31:0] VEC_OFS_FIT = 32'h0000_0300;

    localparam logic [3:0] OUT_SPACING = 4'hA;
    localparam logic [3:0] IN_SPACING_CACHE = 4'h4;
    localparam logic [3:0] IN_SPACING_REG = 4'h2;
    localparam logic [3:0] SPACING_ONE = 4'h1;
    localparam logic [3:0] SPACING_ZERO = 4'h0;
    localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;
    localparam logic [4:0] HOLD_ZERO = 5'h00;
    localparam logic [4:0] HOLD_ONE = 5'h01;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        RS_HOLD = 2'b00,
        RS_HALT = 2'b01,
        RS_RUN = 2'b10
    } ccrg_rst_state_t;

    typedef enum logic [0:0] {
        IQ_IDLE = 1'b0,
        IQ_SERVICE = 1'b1
    } ccrg_irq_state_t;

    typedef enum logic [1:0] {
        CAUSE_NONE = 2'b00,
        CAUSE_EXT = 2'b01,
        CAUSE_PIT = 2'b10,
        CAUSE_FIT = 2'b11
    } ccrg_cause_t;

    // Control-bus write from the core
    typedef struct packed {
        logic strobe;
        logic [9:0] addr;
        logic [31:0] data;
    } ccrg_dcr_req_t;

    // Data-side port read from the core
    typedef struct packed {
        logic strobe;
        logic to_cache;
        logic [31:0] addr;
    } ccrg_rd_req_t;

    // Hardwired instruction answer to a fetch
    typedef struct packed {
        logic valid;
        logic hit;
        logic icache_enable;
        logic [31:0] target;
    } ccrg_fetch_rsp_t;

endpackage : ccrg_pkg

// ### verilog/ccrg_engine_shell.sv
/*
 * Engine shell around a cache-resident processor core: interrupt
 * recognition and vectoring, reset sequencing with halt control, and the
 * 32-bit output and input ports.
 * Assumes the core drives request strobes synchronous to CORE_CLK_I and
 * signals the end of each service routine with a one-cycle pulse.
 */
`timescale 1ns/1ns
module ccrg_engine_shell
    import ccrg_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // User side
    input wire logic EXTERNAL_INTERRUPT_LINE_I,
    input wire logic EXT_RESET_REQ_I,
    input wire logic [31:0] GPIO_IN_I,
    output logic [31:0] GPIO_OUT_O,
    output logic SYSTEM_RESET_NOTIFY_O,
    // Halt controller (JTAG side)
    input wire logic JTAG_HALT_I,
    input wire logic JTAG_UNHALT_I,
    output logic CORE_HALTED_O,
    // Core reset and control
    input wire logic CORE_SYSRESET_REQUEST_I,
    output logic CORE_RESET_O,
    output logic CACHE_DISABLE_O,
    output logic [31:0] CORE_START_PC_O,
    // Interrupt sources and core handshake
    input wire logic PIT_EVENT_I,
    input wire logic FIT_EVENT_I,
    input wire logic CORE_IRQ_ENABLE_I,
    input wire logic CORE_ISR_EXIT_I,
    output logic IRQ_TAKE_O,
    output logic [1:0] IRQ_CAUSE_O,
    output logic [31:0] IRQ_FETCH_ADDR_O,
    // Hardwired instruction fetch
    input wire logic FETCH_REQ_I,
    input wire logic [31:0] FETCH_ADDR_I,
    output ccrg_fetch_rsp_t FETCH_RSP_O,
    // Control-bus output port
    input wire ccrg_dcr_req_t DCR_REQ_I,
    output logic DCR_READY_O,
    output logic DCR_ACK_O,
    // Data-side input port
    input wire ccrg_rd_req_t RD_REQ_I,
    output logic RD_READY_O,
    output logic RD_VALID_O,
    output logic [31:0] RD_DATA_O
);

    ccrg_rst_state_t rst_state_reg;
    ccrg_irq_state_t irq_state_reg;
    logic [4:0] hold_cnt_reg;
    logic halt_reg;
    logic pit_pend_reg;
    logic fit_pend_reg;
    logic take_reg;
    logic [1:0] cause_reg;
    logic [31:0] vec_addr_reg;
    logic [31:0] gpio_out_reg;
    logic [3:0] out_gap_reg;
    logic [3:0] in_gap_reg;
    logic dcr_ack_reg;
    logic rd_valid_reg;
    logic [31:0] rd_data_reg;
    ccrg_fetch_rsp_t fetch_reg;
    logic reset_request;
    logic running;
    logic take_now;
    ccrg_cause_t cause_next;
    logic dcr_accept;
    logic rd_accept;

    function automatic logic [3:0] gap_step(input logic [3:0] gap);
        gap_step = (gap == SPACING_ZERO) ? SPACING_ZERO : gap - SPACING_ONE;
    endfunction : gap_step

    // Reset sources: outside request and core watchdog request
    assign reset_request = EXT_RESET_REQ_I | CORE_SYSRESET_REQUEST_I;
    assign running = (rst_state_reg == RS_RUN);

    // Reset sequencer
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rst_state_reg <= RS_HOLD;
            hold_cnt_reg <= RESET_HOLD_CYCLES;
        end
        else if (reset_request)
        begin
            rst_state_reg <= RS_HOLD;
            hold_cnt_reg <= RESET_HOLD_CYCLES;
        end
        else
        begin
            case (rst_state_reg)
                RS_HOLD:
                begin
                    if (hold_cnt_reg == HOLD_ONE)
                        rst_state_reg <= halt_reg ? RS_HALT : RS_RUN;
                    hold_cnt_reg <= (hold_cnt_reg == HOLD_ZERO) ? HOLD_ZERO
                                  : hold_cnt_reg - HOLD_ONE;
                end
                RS_HALT:
                begin
                    if (!halt_reg)
                        rst_state_reg <= RS_RUN;
                end
                RS_RUN:
                begin
                    if (halt_reg)
                        rst_state_reg <= RS_HALT;
                end
                default:
                    rst_state_reg <= RS_HOLD;
            endcase
        end
    end

    // Halt controller: halted from power-up until JTAG releases it
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            halt_reg <= 1'b1;
        else if (JTAG_HALT_I)
            halt_reg <= 1'b1;
        else if (JTAG_UNHALT_I)
            halt_reg <= 1'b0;
    end

    assign CORE_RESET_O = (rst_state_reg == RS_HOLD);
    assign CACHE_DISABLE_O = (rst_state_reg == RS_HOLD);
    assign CORE_HALTED_O = (rst_state_reg == RS_HALT);
    assign CORE_START_PC_O = RESET_VECTOR;
    assign SYSTEM_RESET_NOTIFY_O = (rst_state_reg == RS_HOLD);

    // Timer events stay pending until taken; a new event wins over the take
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pit_pend_reg <= 1'b0;
            fit_pend_reg <= 1'b0;
        end
        else if (CORE_RESET_O)
        begin
            pit_pend_reg <= 1'b0;
            fit_pend_reg <= 1'b0;
        end
        else
        begin
            pit_pend_reg <= PIT_EVENT_I
                | (pit_pend_reg & !(take_now && cause_next == CAUSE_PIT));
            fit_pend_reg <= FIT_EVENT_I
                | (fit_pend_reg & !(take_now && cause_next == CAUSE_FIT));
        end
    end

    // Priority: external line, then programmable, then fixed timer
    always_comb
    begin
        if (EXTERNAL_INTERRUPT_LINE_I)
            cause_next = CAUSE_EXT;
        else if (pit_pend_reg)
            cause_next = CAUSE_PIT;
        else if (fit_pend_reg)
            cause_next = CAUSE_FIT;
        else
            cause_next = CAUSE_NONE;
    end

    // Nothing is recognised while a service routine runs
    assign take_now = running && CORE_IRQ_ENABLE_I
        && (irq_state_reg == IQ_IDLE) && (cause_next != CAUSE_NONE);

    // Interrupt service tracking and vectoring
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            irq_state_reg <= IQ_IDLE;
            take_reg <= 1'b0;
            cause_reg <= CAUSE_NONE;
            vec_addr_reg <= WORD_ZERO;
        end
        else if (CORE_RESET_O)
        begin
            irq_state_reg <= IQ_IDLE;
            take_reg <= 1'b0;
            cause_reg <= CAUSE_NONE;
            vec_addr_reg <= WORD_ZERO;
        end
        else
        begin
            take_reg <= take_now;
            case (irq_state_reg)
                IQ_IDLE:
                begin
                    if (take_now)
                    begin
                        irq_state_reg <= IQ_SERVICE;
                        cause_reg <= cause_next;
                        case (cause_next)
                            CAUSE_EXT:
                                vec_addr_reg <= VEC_TABLE_BASE + VEC_OFS_EXT;
                            CAUSE_PIT:
                                vec_addr_reg <= VEC_TABLE_BASE + VEC_OFS_PIT;
                            CAUSE_FIT:
                                vec_addr_reg <= VEC_TABLE_BASE + VEC_OFS_FIT;
                            default:
                                vec_addr_reg <= VEC_TABLE_BASE;
                        endcase
                    end
                end
                IQ_SERVICE:
                begin
                    if (CORE_ISR_EXIT_I)
                        irq_state_reg <= IQ_IDLE;
                end
                default:
                    irq_state_reg <= IQ_IDLE;
            endcase
        end
    end

    assign IRQ_TAKE_O = take_reg;
    assign IRQ_CAUSE_O = cause_reg;
    assign IRQ_FETCH_ADDR_O = vec_addr_reg;

    // Hardwired instructions on the reset vector and the vector table
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            fetch_reg <= '0;
        else
        begin
            fetch_reg.valid <= FETCH_REQ_I;
            fetch_reg.hit <= 1'b0;
            fetch_reg.icache_enable <= 1'b0;
            fetch_reg.target <= WORD_ZERO;
            if (FETCH_REQ_I && FETCH_ADDR_I == RESET_VECTOR)
            begin
                fetch_reg.hit <= 1'b1;
                fetch_reg.icache_enable <= 1'b1;
                fetch_reg.target <= USER_ENTRY;
            end
            else if (FETCH_REQ_I && FETCH_ADDR_I[31:16] == VEC_TABLE_TAG)
            begin
                fetch_reg.hit <= 1'b1;
                fetch_reg.target <= TRAP_ADDR;
            end
        end
    end

    assign FETCH_RSP_O = fetch_reg;

    // Output port: control-bus write, spaced by the output interval
    assign DCR_READY_O = (out_gap_reg == SPACING_ZERO);
    assign dcr_accept = DCR_REQ_I.strobe && DCR_READY_O;

    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            gpio_out_reg <= WORD_ZERO;
            out_gap_reg <= SPACING_ZERO;
            dcr_ack_reg <= 1'b0;
        end
        else
        begin
            dcr_ack_reg <= dcr_accept;
            if (dcr_accept)
                out_gap_reg <= OUT_SPACING - SPACING_ONE;
            else
                out_gap_reg <= gap_step(out_gap_reg);
            if (dcr_accept && DCR_REQ_I.addr == OUT_PORT_DCR)
                gpio_out_reg <= DCR_REQ_I.data;
        end
    end

    assign GPIO_OUT_O = gpio_out_reg;
    assign DCR_ACK_O = dcr_ack_reg;

    // Input port: data-side read, spacing by destination of the value
    assign RD_READY_O = (in_gap_reg == SPACING_ZERO);
    assign rd_accept = RD_REQ_I.strobe && RD_READY_O;

    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            in_gap_reg <= SPACING_ZERO;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= WORD_ZERO;
        end
        else
        begin
            rd_valid_reg <= rd_accept;
            if (rd_accept)
                in_gap_reg <= (RD_REQ_I.to_cache ? IN_SPACING_CACHE
                               : IN_SPACING_REG) - SPACING_ONE;
            else
                in_gap_reg <= gap_step(in_gap_reg);
            if (rd_accept)
                rd_data_reg <= (RD_REQ_I.addr == IN_PORT_ADDR) ? GPIO_IN_I
                               : WORD_ZERO;
        end
    end

    assign RD_VALID_O = rd_valid_reg;
    assign RD_DATA_O = rd_data_reg;

endmodule : ccrg_engine_shell

// ### verif/ccrg_user_model.sv
/*
 * User-logic model: interrupt source and input port value.
 * Assumes bench commands that change just after the rising edge.
 */
`timescale 1ns/1ns
module ccrg_user_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic raise_i,
    input wire logic drop_i,
    // Toward the engine
    output logic irq_o,
    output logic [31:0] gin_o
);
    // Request held until the bench drops it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else if (raise_i)
            irq_o <= 1'b1;
        else if (drop_i)
            irq_o <= 1'b0;
    end
    // New value each cycle
    always_ff @(posedge clk_i)
        gin_o <= $urandom;
endmodule : ccrg_user_model

// ### verif/ccrg_engine_shell_asserts.sv
/*
 * Port checker for the engine shell.
 * Assumes it is bound to ccrg_engine_shell, one clock.
 */
`timescale 1ns/1ns
module ccrg_engine_shell_asserts
    import ccrg_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Watched ports
    input wire logic EXT_RESET_REQ_I,
    input wire logic CORE_SYSRESET_REQUEST_I,
    input wire logic JTAG_UNHALT_I,
    input wire logic SYSTEM_RESET_NOTIFY_O,
    input wire logic CACHE_DISABLE_O,
    input wire logic CORE_HALTED_O,
    input wire logic IRQ_TAKE_O,
    input wire logic [1:0] IRQ_CAUSE_O,
    input wire logic [31:0] IRQ_FETCH_ADDR_O,
    input wire logic FETCH_REQ_I,
    input wire logic [31:0] FETCH_ADDR_I,
    input wire ccrg_fetch_rsp_t FETCH_RSP_O,
    input wire ccrg_dcr_req_t DCR_REQ_I,
    input wire logic DCR_READY_O,
    input wire logic DCR_ACK_O,
    input wire logic [31:0] GPIO_OUT_O,
    input wire ccrg_rd_req_t RD_REQ_I,
    input wire logic RD_READY_O,
    input wire logic RD_VALID_O,
    input wire logic [31:0] RD_DATA_O,
    input wire logic [31:0] GPIO_IN_I
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);

    a_take_pulse: assert property (IRQ_TAKE_O |=> !IRQ_TAKE_O [*3])
        else $error("interrupt taken again in service");
    a_vector_addr: assert property (IRQ_TAKE_O |->
        IRQ_CAUSE_O != CAUSE_NONE &&
        IRQ_FETCH_ADDR_O == VEC_TABLE_BASE + {22'h0, IRQ_CAUSE_O, 8'h00})
        else $error("bad vector address");
    a_boot_fetch: assert property (FETCH_REQ_I &&
        FETCH_ADDR_I == RESET_VECTOR |=> FETCH_RSP_O == {3'h7, USER_ENTRY})
        else $error("bad boot fetch");
    a_out_write: assert property (DCR_REQ_I.strobe && DCR_READY_O &&
        DCR_REQ_I.addr == OUT_PORT_DCR |=>
        DCR_ACK_O && GPIO_OUT_O == $past(DCR_REQ_I.data))
        else $error("output port not written");
    a_out_space: assert property (DCR_ACK_O |=>
        !DCR_ACK_O [*8] ##1 !DCR_ACK_O)
        else $error("output writes too close");
    a_in_data: assert property (RD_REQ_I.strobe && RD_READY_O &&
        RD_REQ_I.addr == IN_PORT_ADDR |=>
        RD_VALID_O && RD_DATA_O == $past(GPIO_IN_I))
        else $error("input port data wrong");
    a_in_cache: assert property (RD_REQ_I.strobe && RD_READY_O &&
        RD_REQ_I.to_cache |=> !RD_READY_O [*3] ##1 RD_READY_O)
        else $error("cache read spacing wrong");
    a_in_reg: assert property (RD_REQ_I.strobe && RD_READY_O &&
        !RD_REQ_I.to_cache |=> !RD_READY_O ##1 RD_READY_O)
        else $error("register read spacing wrong");
    a_reset_req: assert property (EXT_RESET_REQ_I ||
        CORE_SYSRESET_REQUEST_I |=> SYSTEM_RESET_NOTIFY_O && CACHE_DISABLE_O)
        else $error("reset request not honoured");
    a_halt_hold: assert property (CORE_HALTED_O && !JTAG_UNHALT_I &&
        !$past(JTAG_UNHALT_I) && !EXT_RESET_REQ_I &&
        !CORE_SYSRESET_REQUEST_I |=> CORE_HALTED_O)
        else $error("halt released unasked");
endmodule : ccrg_engine_shell_asserts

bind ccrg_engine_shell ccrg_engine_shell_asserts u_asserts (
    .CORE_CLK_I, .RST_I, .EXT_RESET_REQ_I, .CORE_SYSRESET_REQUEST_I,
    .JTAG_UNHALT_I, .SYSTEM_RESET_NOTIFY_O, .CACHE_DISABLE_O,
    .CORE_HALTED_O, .IRQ_TAKE_O, .IRQ_CAUSE_O, .IRQ_FETCH_ADDR_O,
    .FETCH_REQ_I, .FETCH_ADDR_I, .FETCH_RSP_O, .DCR_REQ_I, .DCR_READY_O,
    .DCR_ACK_O, .GPIO_OUT_O, .RD_REQ_I, .RD_READY_O, .RD_VALID_O,
    .RD_DATA_O, .GPIO_IN_I
);

// ### verif/ccrg_engine_shell_tb_top.sv
/*
 * Testbench for the engine shell with a user-logic model.
 * Assumes the bound checker and a 100 MHz clock.
 */
`timescale 1ns/1ns
module ccrg_engine_shell_tb_top
    import ccrg_pkg::*;
;
    logic clk, rst, xrst, wdog, halt, unhalt, programmable_interval_timer, fit, ien, isr_exit;
    logic freq, raise, drop, irq, notify, halted, creset, cdis;
    logic irq_take, dready, dack, rready, rvalid;
    logic [1:0] cause;
    logic [31:0] faddr, gin, gout, gexp, pc, vaddr, rdata, r;
    ccrg_fetch_rsp_t frsp;
    ccrg_dcr_req_t dreq;
    ccrg_rd_req_t rreq;
    int miscompares, samples_checked, i;

    ccrg_engine_shell DUT (
        .CORE_CLK_I(clk), .RST_I(rst), .EXTERNAL_INTERRUPT_LINE_I(irq),
        .EXT_RESET_REQ_I(xrst), .GPIO_IN_I(gin), .GPIO_OUT_O(gout),
        .SYSTEM_RESET_NOTIFY_O(notify), .JTAG_HALT_I(halt),
        .JTAG_UNHALT_I(unhalt), .CORE_HALTED_O(halted),
        .CORE_SYSRESET_REQUEST_I(wdog), .CORE_RESET_O(creset),
        .CACHE_DISABLE_O(cdis), .CORE_START_PC_O(pc), .PIT_EVENT_I(programmable_interval_timer),
        .FIT_EVENT_I(fit), .CORE_IRQ_ENABLE_I(ien),
        .CORE_ISR_EXIT_I(isr_exit), .IRQ_TAKE_O(irq_take),
        .IRQ_CAUSE_O(cause), .IRQ_FETCH_ADDR_O(vaddr),
        .FETCH_REQ_I(freq), .FETCH_ADDR_I(faddr), .FETCH_RSP_O(frsp),
        .DCR_REQ_I(dreq), .DCR_READY_O(dready), .DCR_ACK_O(dack),
        .RD_REQ_I(rreq), .RD_READY_O(rready), .RD_VALID_O(rvalid),
        .RD_DATA_O(rdata)
    );
    ccrg_user_model u_user (
        .clk_i(clk), .rst_i(rst), .raise_i(raise), .drop_i(drop),
        .irq_o(irq), .gin_o(gin)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [34:0] seen,
        input logic [34:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    function automatic logic sig(input int s);
        return s == 0 ? irq_take : s == 1 ? halted : !creset;
    endfunction : sig

    task automatic wait_hi(input int s);
        int n;
        for (n = 0; n < 60 && sig(s) !== 1'b1; n++)
            tick;
        if (n == 60)
        begin
            miscompares++;
            results;
        end
    endtask : wait_hi

    task automatic quiet(input int n);
        repeat (n)
        begin
            tick;
            check("no take", irq_take, 1'b0);
        end
    endtask : quiet

    task automatic unhalt_core;
        unhalt = 1'b1;
        tick;
        unhalt = 1'b0;
        tick;
        tick;
        check("halted", halted, 1'b0);
    endtask : unhalt_core

    task automatic fetch(input logic [31:0] a, input logic [34:0] e);
        faddr = a;
        tick;
        check("fetch", frsp, e);
    endtask : fetch

    task automatic port_run(input logic device_control_reg_bus, input logic cache,
        input logic sel);
        int t, last;
        logic acc;
        logic [31:0] e;
        last = -1;
        dreq = {device_control_reg_bus, sel ? OUT_PORT_DCR : 10'h3F0, $urandom};
        rreq = {!device_control_reg_bus, cache, sel ? IN_PORT_ADDR : 32'h0100_0004};
        for (t = 0; t < 30; t++)
        begin
            acc = device_control_reg_bus ? dready : rready;
            e = device_control_reg_bus ? (sel ? dreq.data : gexp) : (sel ? gin : WORD_ZERO);
            tick;
            if (acc === 1'b1)
            begin
                if (last >= 0)
                    check("spacing", t - last, device_control_reg_bus ? 10 : cache ? 4 : 2);
                check("answer", device_control_reg_bus ? dack : rvalid, 1'b1);
                check("port data", device_control_reg_bus ? gout : rdata, e);
                if (device_control_reg_bus)
                    gexp = e;
                last = t;
                dreq.data = $urandom;
            end
        end
        dreq = '0;
        rreq = '0;
        tick;
    endtask : port_run

    task automatic take_irq(input logic [1:0] c, input logic [31:0] a,
        input logic d);
        wait_hi(0);
        check("cause", cause, c);
        check("vector", vaddr, a);
        quiet(4);
        drop = d;
        tick;
        drop = 1'b0;
        isr_exit = 1'b1;
        tick;
        isr_exit = 1'b0;
    endtask : take_irq

    initial
    begin
        rst = 1'b1;
        {xrst, wdog, halt, unhalt, programmable_interval_timer, fit, ien, isr_exit} = '0;
        {freq, raise, drop} = '0;
        faddr = '0;
        dreq = '0;
        rreq = '0;
        gexp = WORD_ZERO;
        miscompares = 0;
        samples_checked = 0;
        r = $urandom(32'hBF8A);
        repeat (8) @(posedge clk);
        #1;
        check("notify", notify, 1'b1);
        check("cache off", cdis, 1'b1);
        check("start pc", pc, RESET_VECTOR);
        rst = 1'b0;
        wait_hi(1);
        check("core reset", creset, 1'b0);
        unhalt_core;
        freq = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            r = $urandom;
            fetch(RESET_VECTOR, {3'h7, USER_ENTRY});
            fetch({VEC_TABLE_TAG, r[15:0]}, {3'h6, TRAP_ADDR});
            fetch({4'h0, r[27:0]}, {3'h4, WORD_ZERO});
        end
        freq = 1'b0;
        port_run(1'b1, 1'b0, 1'b1);
        port_run(1'b1, 1'b0, 1'b0);
        port_run(1'b0, 1'b1, 1'b1);
        port_run(1'b0, 1'b0, 1'b1);
        port_run(1'b0, 1'b1, 1'b0);
        raise = 1'b1;
        tick;
        raise = 1'b0;
        quiet(5);
        ien = 1'b1;
        take_irq(CAUSE_EXT, VEC_TABLE_BASE + VEC_OFS_EXT, 1'b0);
        take_irq(CAUSE_EXT, VEC_TABLE_BASE + VEC_OFS_EXT, 1'b1);
        quiet(6);
        {programmable_interval_timer, fit} = 2'h3;
        tick;
        {programmable_interval_timer, fit} = 2'h0;
        take_irq(CAUSE_PIT, VEC_TABLE_BASE + VEC_OFS_PIT, 1'b0);
        take_irq(CAUSE_FIT, VEC_TABLE_BASE + VEC_OFS_FIT, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            xrst = (i == 0);
            wdog = (i == 1);
            tick;
            {xrst, wdog} = 2'h0;
            check("notify", notify, 1'b1);
            check("cache off", cdis, 1'b1);
            check("port kept", gout, gexp);
            wait_hi(2);
            check("halted", halted, 1'b0);
        end
        halt = 1'b1;
        tick;
        halt = 1'b0;
        wait_hi(1);
        unhalt_core;
        results;
    end
endmodule : ccrg_engine_shell_tb_top
